// ===== idp_page_gen.sv
// idp_page_gen: builds the 256-word identify parameter page on request
// assumes the sector transfer logic pulls words through out_valid/out_ready
// Functional notes
// - word 0 reports removable, fast, non-magnetic
// - word 1 default cylinders equal actual
// - words 3-6 heads, bytes, sectors geometry
// - words 7-8 total sectors double word
// - serial words 10-19, right justified, spaces
// - word 20 buffer type 0002h
// - word 21 buffer two sectors
// - word 22 long command ECC bytes
// - words 23-26 firmware revision text
// - model words 27-46, left justified, spaces
// - word 47 max multiple sectors
// - word 48 no double word
// - word 49 no DMA, LBA supported
// - word 51 PIO timing mode
// - word 52 no DMA timing mode
// - word 53 bits 0,1 validity flags
// - words 54-56 current translation geometry
// - words 57-58 current capacity product
// - word 59 high byte always 01h
// - multiple setting 00h after reset or a zero count, 01h after a nonzero count
// - words 60-61 LBA-only sector count
// - word 64 PIO modes 3 and 4
// - reserved bits and words read zero
// - page delivered like a single-sector read
// - word 0 fixed 848ah
// - model earlier character in high byte
`timescale 1ns/1ns
module idp_page_gen #(
  parameter logic [8*20-1:0] SERIAL   = "00000001",
  parameter logic [8*8-1:0]  FIRMWARE = "Rev 1.00",
  parameter logic [8*40-1:0] MODEL    = "Flash Storage Card"
) (
  // clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        reset_i,
  // command side
  input  wire logic        start_i,
  input  wire logic        set_mult_i,
  input  wire logic [7:0]  mult_count_i,
  output logic             busy_o,
  output logic             done_o,
  // card geometry
  input  wire logic [15:0] cyl_i,
  input  wire logic [15:0] heads_i,
  input  wire logic [15:0] spt_i,
  input  wire logic [31:0] total_sectors_i,
  input  wire logic [15:0] cur_cyl_i,
  input  wire logic [15:0] cur_heads_i,
  input  wire logic [15:0] cur_spt_i,
  // status
  output logic [7:0]       mult_setting_o,
  // page stream to sector buffer
  output logic             out_valid_o,
  input  wire logic        out_ready_i,
  output logic [15:0]      out_data_o
);
  typedef enum logic [1:0] {IDP_IDLE, IDP_FETCH, IDP_PUSH} idp_state_t;

  idp_state_t  state_r;
  logic [7:0]  addr_r;
  logic [7:0]  mult_r;
  logic [15:0] word_r;
  logic [15:0] str_word;
  logic [15:0] fixed_word;
  logic [31:0] cap_r;
  logic        fifo_in_ready;
  logic        fifo_in_valid;
  logic        is_str;
  logic        last;

  // ==========================================================
  // helpers
  function automatic logic in_range(input logic [7:0] a, input logic [7:0] lo,
                                    input logic [7:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction

  // ==========================================================
  // string words
  idp_str_rom #(
    .SERIAL   (SERIAL),
    .FIRMWARE (FIRMWARE),
    .MODEL    (MODEL)
  ) u_str (
    .ref_clk_i (ref_clk_i),
    .reset_i   (reset_i),
    .addr_i    (addr_r),
    .data_o    (str_word)
  );

  assign is_str = in_range(addr_r, idp_pkg::W_SER_LO, idp_pkg::W_SER_HI) |
                  in_range(addr_r, idp_pkg::W_FW_LO, idp_pkg::W_FW_HI) |
                  in_range(addr_r, idp_pkg::W_MOD_LO, idp_pkg::W_MOD_HI);

  // ==========================================================
  // numeric words
  always_comb begin
    case (addr_r)
      idp_pkg::W_GENCFG:   fixed_word = idp_pkg::GENCFG_VAL;
      idp_pkg::W_DEF_CYL:  fixed_word = cyl_i;
      idp_pkg::W_DEF_HEAD: fixed_word = heads_i;
      idp_pkg::W_UF_TRK:   fixed_word = idp_pkg::UF_TRK_VAL;
      idp_pkg::W_UF_SEC:   fixed_word = idp_pkg::UF_SEC_VAL;
      idp_pkg::W_DEF_SPT:  fixed_word = spt_i;
      idp_pkg::W_TOT_MSW:  fixed_word = total_sectors_i[31:16];
      idp_pkg::W_TOT_LSW:  fixed_word = total_sectors_i[15:0];
      idp_pkg::W_BUF_TYPE: fixed_word = idp_pkg::BUF_TYPE_VAL;
      idp_pkg::W_BUF_SIZE: fixed_word = idp_pkg::BUF_SIZE_VAL;
      idp_pkg::W_ECC:      fixed_word = idp_pkg::ECC_VAL;
      idp_pkg::W_MULT_MAX: fixed_word = idp_pkg::MULT_MAX_VAL;
      idp_pkg::W_DWORD:    fixed_word = idp_pkg::DWORD_VAL;
      idp_pkg::W_CAPAB:    fixed_word = idp_pkg::CAPAB_VAL;
      idp_pkg::W_PIO_MODE: fixed_word = idp_pkg::PIO_MODE_VAL;
      idp_pkg::W_DMA_MODE: fixed_word = idp_pkg::DMA_MODE_VAL;
      idp_pkg::W_VALID:    fixed_word = idp_pkg::VALID_VAL;
      idp_pkg::W_CUR_CYL:  fixed_word = cur_cyl_i;
      idp_pkg::W_CUR_HEAD: fixed_word = cur_heads_i;
      idp_pkg::W_CUR_SPT:  fixed_word = cur_spt_i;
      idp_pkg::W_CAP_LSW:  fixed_word = cap_r[15:0];
      idp_pkg::W_CAP_MSW:  fixed_word = cap_r[31:16];
      idp_pkg::W_MULT_SET: fixed_word = {idp_pkg::MULT_VLD, mult_r};
      idp_pkg::W_LBA_LSW:  fixed_word = total_sectors_i[15:0];
      idp_pkg::W_LBA_MSW:  fixed_word = total_sectors_i[31:16];
      idp_pkg::W_ADV_PIO:  fixed_word = idp_pkg::ADV_PIO_VAL;
      default:             fixed_word = 16'h0000;
    endcase
  end

  // ==========================================================
  // current capacity, computed at start so the multiply has a full cycle
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      cap_r <= 32'h0000_0000;
    end else if (start_i && state_r == IDP_IDLE) begin
      // widen each factor first so the product keeps its upper bits
      cap_r <= 32'(cur_cyl_i) * 32'(cur_heads_i) * 32'(cur_spt_i);
    end
  end

  // ==========================================================
  // multiple-sector setting: only 00h or 01h is ever reported
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      mult_r <= idp_pkg::MULT_OFF;
    end else if (set_mult_i) begin
      mult_r <= (mult_count_i == 8'h00) ? idp_pkg::MULT_OFF : idp_pkg::MULT_ON;
    end
  end

  assign mult_setting_o = mult_r;

  // ==========================================================
  // word sequencer: fetch takes one cycle because the string rom is registered
  assign last          = (addr_r == idp_pkg::LAST_WORD);
  assign fifo_in_valid = (state_r == IDP_PUSH);

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_r <= IDP_IDLE;
      addr_r  <= 8'h00;
      word_r  <= 16'h0000;
      done_o  <= 1'b0;
    end else begin
      done_o <= 1'b0;
      case (state_r)
        IDP_IDLE: begin
          if (start_i) begin
            addr_r  <= 8'h00;
            state_r <= IDP_FETCH;
          end
        end
        IDP_FETCH: begin
          word_r  <= fixed_word;
          state_r <= IDP_PUSH;
        end
        IDP_PUSH: begin
          if (fifo_in_ready) begin
            if (last) begin
              done_o  <= 1'b1;
              state_r <= IDP_IDLE;
            end else begin
              addr_r  <= 8'(addr_r + 8'h01);
              state_r <= IDP_FETCH;
            end
          end
        end
        default: state_r <= IDP_IDLE;
      endcase
    end
  end

  assign busy_o = (state_r != IDP_IDLE);

  // ==========================================================
  // sector buffer feed; the reader stalls us by holding out_ready low
  idp_fifo #(
    .WIDTH (idp_pkg::WORD_W),
    .DEPTH (idp_pkg::FIFO_DEPTH)
  ) u_fifo (
    .ref_clk_i   (ref_clk_i),
    .reset_i     (reset_i),
    .in_valid_i  (fifo_in_valid),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (is_str ? str_word : word_r),
    .out_valid_o (out_valid_o),
    .out_ready_i (out_ready_i),
    .out_data_o  (out_data_o),
    // a new page drops any words a previous reader left unread
    .flush_i     (start_i && state_r == IDP_IDLE)
  );
endmodule

// ===== idp_pkg.sv
// identify parameter page: shared constants
// assumes a single 50 MHz clock domain; no bus, all settings are ports
package idp_pkg;

  // ==========================================================
  // page geometry
  localparam int          PAGE_WORDS = 256;
  localparam logic [7:0]  LAST_WORD  = 8'hff;
  localparam int          FIFO_DEPTH = 8;
  localparam int          WORD_W     = 16;

  // ==========================================================
  // word addresses
  localparam logic [7:0] W_GENCFG   = 8'h00;
  localparam logic [7:0] W_DEF_CYL  = 8'h01;
  localparam logic [7:0] W_DEF_HEAD = 8'h03;
  localparam logic [7:0] W_UF_TRK   = 8'h04;
  localparam logic [7:0] W_UF_SEC   = 8'h05;
  localparam logic [7:0] W_DEF_SPT  = 8'h06;
  localparam logic [7:0] W_TOT_MSW  = 8'h07;
  localparam logic [7:0] W_TOT_LSW  = 8'h08;
  localparam logic [7:0] W_SER_LO   = 8'h0a;
  localparam logic [7:0] W_SER_HI   = 8'h13;
  localparam logic [7:0] W_BUF_TYPE = 8'h14;
  localparam logic [7:0] W_BUF_SIZE = 8'h15;
  localparam logic [7:0] W_ECC      = 8'h16;
  localparam logic [7:0] W_FW_LO    = 8'h17;
  localparam logic [7:0] W_FW_HI    = 8'h1a;
  localparam logic [7:0] W_MOD_LO   = 8'h1b;
  localparam logic [7:0] W_MOD_HI   = 8'h2e;
  localparam logic [7:0] W_MULT_MAX = 8'h2f;
  localparam logic [7:0] W_DWORD    = 8'h30;
  localparam logic [7:0] W_CAPAB    = 8'h31;
  localparam logic [7:0] W_PIO_MODE = 8'h33;
  localparam logic [7:0] W_DMA_MODE = 8'h34;
  localparam logic [7:0] W_VALID    = 8'h35;
  localparam logic [7:0] W_CUR_CYL  = 8'h36;
  localparam logic [7:0] W_CUR_HEAD = 8'h37;
  localparam logic [7:0] W_CUR_SPT  = 8'h38;
  localparam logic [7:0] W_CAP_LSW  = 8'h39;
  localparam logic [7:0] W_CAP_MSW  = 8'h3a;
  localparam logic [7:0] W_MULT_SET = 8'h3b;
  localparam logic [7:0] W_LBA_LSW  = 8'h3c;
  localparam logic [7:0] W_LBA_MSW  = 8'h3d;
  localparam logic [7:0] W_ADV_PIO  = 8'h40;

  // ==========================================================
  // fixed field values
  localparam logic [15:0] GENCFG_VAL   = 16'h848a;
  localparam logic [15:0] UF_TRK_VAL   = 16'h0000;
  localparam logic [15:0] UF_SEC_VAL   = 16'h0240;
  localparam logic [15:0] BUF_TYPE_VAL = 16'h0002;
  localparam logic [15:0] BUF_SIZE_VAL = 16'h0002;
  localparam logic [15:0] ECC_VAL      = 16'h0004;
  localparam logic [15:0] MULT_MAX_VAL = 16'h0001;
  localparam logic [15:0] DWORD_VAL    = 16'h0000;
  localparam logic [15:0] CAPAB_VAL    = 16'h0200;
  localparam logic [15:0] PIO_MODE_VAL = 16'h0200;
  localparam logic [15:0] DMA_MODE_VAL = 16'h0000;
  localparam logic [15:0] VALID_VAL    = 16'h0003;
  localparam logic [15:0] ADV_PIO_VAL  = 16'h0003;
  localparam logic [7:0]  MULT_VLD     = 8'h01;
  localparam logic [7:0]  MULT_OFF     = 8'h00;
  localparam logic [7:0]  MULT_ON      = 8'h01;
  localparam logic [7:0]  SPACE_CHR    = 8'h20;

  // ==========================================================
  // string lengths in characters
  localparam int SER_CHARS = 20;
  localparam int FW_CHARS  = 8;
  localparam int MOD_CHARS = 40;

endpackage

// ===== idp_fifo.sv
// idp_fifo: small synchronous fifo with valid/ready on both sides
// assumes one clock and asynchronous active-high reset
`timescale 1ns/1ns
module idp_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic             ref_clk_i,
  input  wire logic             reset_i,
  // write side
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // read side
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o,
  // clear
  input  wire logic             flush_i
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wr_ptr_r;
  logic [AW-1:0]    rd_ptr_r;
  logic [AW:0]      count_r;
  logic             push;
  logic             pop;

  assign in_ready_o  = (count_r != DEPTH[AW:0]);
  assign out_valid_o = (count_r != '0);
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;
  // read data is not a register: out_data_o reads the head of queue straight from mem_r
  assign out_data_o  = mem_r[rd_ptr_r];

  // ==========================================================
  // storage
  always_ff @(posedge ref_clk_i) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data_i;
    end
  end

  // ==========================================================
  // pointers
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else if (flush_i) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= AW'(wr_ptr_r + 1'b1);
      end
      if (pop) begin
        rd_ptr_r <= AW'(rd_ptr_r + 1'b1);
      end
      count_r <= (AW+1)'(count_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
    end
  end
endmodule

// ===== idp_str_rom.sv
// idp_str_rom: holds serial, firmware and model text, returns one word
// assumes strings are loaded as constants by parameter; read data registered
`timescale 1ns/1ns
module idp_str_rom #(
  parameter logic [8*20-1:0] SERIAL   = "12345",
  parameter logic [8*8-1:0]  FIRMWARE = "Rev 1.00",
  parameter logic [8*40-1:0] MODEL    = "Storage Card"
) (
  // clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        reset_i,
  // lookup
  input  wire logic [7:0]  addr_i,
  output logic      [15:0] data_o
);
  // ==========================================================
  // character fetch with space padding
  function automatic logic [7:0] ser_chr(input int i);
    logic [7:0] c;
    // right justified: leading nulls become spaces
    c = SERIAL[8*(19-i) +: 8];
    return (c == 8'h00) ? idp_pkg::SPACE_CHR : c;
  endfunction

  function automatic logic [7:0] mod_chr(input int i, input int n);
    logic [7:0] c;
    logic [8*40-1:0] s;
    int k;
    // left justified: shift text up, trailing slots become spaces
    s = MODEL;
    k = 0;
    while (k < 40 && s[8*39 +: 8] == 8'h00) begin
      s = s << 8;
      k = k + 1;
    end
    c = s[8*(39-i) +: 8];
    return (c == 8'h00 || i >= n) ? idp_pkg::SPACE_CHR : c;
  endfunction

  logic [15:0] word;
  int          idx;

  always_comb begin
    idx  = 0;
    word = 16'h0000;
    if (addr_i >= idp_pkg::W_SER_LO && addr_i <= idp_pkg::W_SER_HI) begin
      idx  = 2 * int'(addr_i - idp_pkg::W_SER_LO);
      word = {ser_chr(idx), ser_chr(idx + 1)};
    end else if (addr_i >= idp_pkg::W_FW_LO && addr_i <= idp_pkg::W_FW_HI) begin
      idx  = 2 * int'(addr_i - idp_pkg::W_FW_LO);
      word = {FIRMWARE[8*(7-idx) +: 8], FIRMWARE[8*(6-idx) +: 8]};
    end else if (addr_i >= idp_pkg::W_MOD_LO && addr_i <= idp_pkg::W_MOD_HI) begin
      // earlier character in the high byte
      idx  = 2 * int'(addr_i - idp_pkg::W_MOD_LO);
      word = {mod_chr(idx, 40), mod_chr(idx + 1, 40)};
    end
  end

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      data_o <= 16'h0000;
    end else begin
      data_o <= word;
    end
  end
endmodule

// ===== idp_page_monitor.sv
// idp_page_monitor: port-level checker for idp_page_gen
// assumes one clock domain; bound to the design at the foot of this file
`timescale 1ns/1ns
module idp_page_monitor (
  // clock and reset
  input wire logic        ref_clk_i,
  input wire logic        reset_i,
  // command side
  input wire logic        start_i,
  input wire logic        set_mult_i,
  input wire logic [7:0]  mult_count_i,
  input wire logic        busy_o,
  input wire logic        done_o,
  input wire logic [7:0]  mult_setting_o,
  // page stream
  input wire logic        out_valid_o,
  input wire logic        out_ready_i,
  input wire logic [15:0] out_data_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);

  // ==========================================
  // page start
  sequence s_start;
    start_i && !busy_o && !out_valid_o;
  endsequence
  sequence s_first_word;
    ##3 out_valid_o;
  endsequence

  a_start_sets_busy: assert property (start_i && !busy_o |=> busy_o)
    else $error("busy did not follow start");
  a_first_word_time: assert property (s_start |-> s_first_word)
    else $error("first word late or early");
  a_first_word_val: assert property (s_start |-> ##3 out_data_o == 16'h848a)
    else $error("first word is not the configuration word");
  a_word_held: assert property (out_valid_o && !out_ready_i |=>
      out_valid_o && $stable(out_data_o))
    else $error("word changed before it was taken");

  // ==========================================
  // completion and multiple setting
  a_done_single: assert property (done_o |=> !done_o)
    else $error("done wider than one cycle");
  a_done_idle: assert property (done_o |-> ##[0:1] !busy_o)
    else $error("busy kept after done");
  a_mult_update: assert property (set_mult_i |=>
      mult_setting_o == (($past(mult_count_i) != 8'h00) ? 8'h01 : 8'h00))
    else $error("multiple setting wrong after set");
  a_mult_hold: assert property (!set_mult_i |=> $stable(mult_setting_o))
    else $error("multiple setting moved without set");
  a_mult_range: assert property (mult_setting_o == 8'h00 || mult_setting_o == 8'h01)
    else $error("multiple setting outside 00h and 01h");
endmodule

bind idp_page_gen idp_page_monitor mon_u (
  .ref_clk_i(ref_clk_i), .reset_i(reset_i), .start_i(start_i), .set_mult_i(set_mult_i),
  .mult_count_i(mult_count_i), .busy_o(busy_o), .done_o(done_o),
  .mult_setting_o(mult_setting_o), .out_valid_o(out_valid_o), .out_ready_i(out_ready_i),
  .out_data_o(out_data_o)
);

// ===== idp_host_model.sv
// idp_host_model: host reader pulling page words one by one
// assumes valid/ready stream; ready moves only on the falling edge
`timescale 1ns/1ns
module idp_host_model (
  // clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        reset_i,
  // control from the bench
  input  wire logic        clear_i,
  input  wire logic        stall_i,
  // stream
  input  wire logic        out_valid_i,
  input  wire logic [15:0] out_data_i,
  output logic             out_ready_o
);
  logic [15:0] page [0:255];
  int          count;
  int          tick;

  // words are taken only where valid and ready meet
  always @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i || clear_i) begin
      count <= 0;
    end else if (out_valid_i && out_ready_o) begin
      if (count < 256) page[count] <= out_data_i;
      count <= count + 1;
    end
  end

  // a slow reader accepts one word in four, so the fifo fills
  always @(negedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      tick        <= 0;
      out_ready_o <= 1'b0;
    end else begin
      tick        <= tick + 1;
      out_ready_o <= !stall_i || (tick % 4 == 0);
    end
  end
endmodule

// ===== idp_page_gen_tb.sv
// idp_page_gen_tb: reads whole pages through the host model and compares them
// assumes package, fifo, string rom, design and checker compiled first
`timescale 1ns/1ns
module idp_page_gen_tb;
  localparam logic [159:0] SER_S = "SN4711";
  localparam logic [63:0]  FW_S  = "Rev 2.31";
  localparam logic [319:0] MOD_S = "Test Card 64";
  logic        clk, rst, start, set_mult, busy, done, ovalid, oready, hclr, hstall;
  logic [7:0]  mcount, mset, mexp;
  logic [15:0] cyl, heads, spt, ccyl, cheads, cspt, odata;
  logic [31:0] tot;
  int          failures, cmp_count;

  idp_page_gen #(.SERIAL(SER_S), .FIRMWARE(FW_S), .MODEL(MOD_S)) dut_u (
    .ref_clk_i(clk), .reset_i(rst), .start_i(start), .set_mult_i(set_mult),
    .mult_count_i(mcount), .busy_o(busy), .done_o(done), .cyl_i(cyl), .heads_i(heads),
    .spt_i(spt), .total_sectors_i(tot), .cur_cyl_i(ccyl), .cur_heads_i(cheads),
    .cur_spt_i(cspt), .mult_setting_o(mset), .out_valid_o(ovalid), .out_ready_i(oready),
    .out_data_o(odata));
  idp_host_model hm_u (.ref_clk_i(clk), .reset_i(rst), .clear_i(hclr), .stall_i(hstall),
    .out_valid_i(ovalid), .out_data_i(odata), .out_ready_o(oready));

  // ==========================================
  // expected page
  function automatic logic [7:0] schr(input int k);
    logic [7:0] c;
    c = SER_S[8*(19-k)+:8];
    return (c == 8'h00) ? 8'h20 : c;
  endfunction
  function automatic logic [7:0] mchr(input int k);
    int n;
    n = 0;
    while (n < 40 && MOD_S[8*(39-n)+:8] == 8'h00) n++;
    return (k + n < 40) ? MOD_S[8*(39-k-n)+:8] : 8'h20;
  endfunction
  function automatic logic [15:0] exp_word(input int w);
    logic [31:0] cap;
    int          k;
    cap = 32'(ccyl) * 32'(cheads) * 32'(cspt);
    k = 2 * (w - 10);
    if (w >= 10 && w <= 19) return {schr(k), schr(k + 1)};
    k = 2 * (w - 23);
    if (w >= 23 && w <= 26) return {FW_S[8*(7-k)+:8], FW_S[8*(6-k)+:8]};
    k = 2 * (w - 27);
    if (w >= 27 && w <= 46) return {mchr(k), mchr(k + 1)};
    case (w)
      0: return 16'h848a;
      1: return cyl;
      3: return heads;
      5: return 16'h0240;
      6: return spt;
      7: return tot[31:16];
      8: return tot[15:0];
      20: return 16'h0002;
      21: return 16'h0002;
      22: return idp_pkg::ECC_VAL;
      47: return idp_pkg::MULT_MAX_VAL;
      49: return 16'h0200;
      51: return idp_pkg::PIO_MODE_VAL;
      53: return 16'h0003;
      54: return ccyl;
      55: return cheads;
      56: return cspt;
      57: return cap[15:0];
      58: return cap[31:16];
      59: return {8'h01, mexp};
      60: return tot[15:0];
      61: return tot[31:16];
      64: return 16'h0003;
      default: return 16'h0000;
    endcase
  endfunction

  // ==========================================
  // tasks
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_words(input int lo, input int hi);
    for (int i = lo; i <= hi; i++) check($sformatf("word %0d", i), exp_word(i), hm_u.page[i]);
  endtask
  task automatic set_mult_to(input logic [7:0] n);
    @(negedge clk);
    mcount = n;
    set_mult = 1'b1;
    mexp = (n != 8'h00) ? 8'h01 : 8'h00;
    @(negedge clk);
    set_mult = 1'b0;
    check("mult setting", {8'h00, mexp}, {8'h00, mset});
  endtask
  // restart pulses start mid-page; it must be ignored
  task automatic run_page(input logic stall, input logic restart, input string name);
    int dn;
    dn = 0;
    @(negedge clk);
    hclr = 1'b1;
    hstall = stall;
    start = 1'b1;
    @(negedge clk);
    hclr = 1'b0;
    start = 1'b0;
    for (int i = 0; i < 4000; i++) begin
      @(negedge clk);
      start = restart && (i == 20);
      if (done === 1'b1) dn++;
      if (hm_u.count >= 256 && ovalid === 1'b0 && i > 40) break;
    end
    repeat (20) @(negedge clk);
    check("page words", 16'd256, 16'(hm_u.count));
    check("done pulses", 16'd1, 16'(dn));
    check("busy idle", 16'h0, {15'h0, busy});
    chk_words(0, 9);
    chk_words(10, 46);
    chk_words(47, 63);
    chk_words(64, 255);
    $display("test %s finished", name);
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // ==========================================
  // run
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    #400000;
    failures++;
    stop_test();
  end
  initial begin
    failures = 0;
    cmp_count = 0;
    rst = 1'b1;
    {start, set_mult, hclr, hstall} = 4'h0;
    mcount = 8'h00;
    mexp = 8'h00;
    {cyl, heads, spt, tot} = {16'h03d4, 16'h0010, 16'h0020, 32'h0007a400};
    {ccyl, cheads, cspt} = {16'h0123, 16'h000f, 16'h003f};
    repeat (4) @(negedge clk);
    rst = 1'b0;
    check("reset mult", 16'h0, {8'h00, mset});
    check("reset valid", 16'h0, {15'h0, ovalid});
    $display("test reset finished");
    run_page(1'b0, 1'b0, "plain");
    {cyl, tot, ccyl, cheads} = {16'h1fff, 32'hffff0001, 16'hffff, 16'h0010};
    set_mult_to(8'h10);
    run_page(1'b1, 1'b1, "stalled");
    set_mult_to(8'h00);
    run_page(1'b0, 1'b0, "cleared");
    stop_test();
  end
endmodule
